// ===== chip_select_decode.sv
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Overview of operation
// RQ1: Select one's low range holds only when address 15:0 lies within start and stop inclusive.
// RQ2: Select one also needs address 27:16 equal to its 12-bit high value.
// RQ3: Select one fires only when range, high match and the chosen qualifier all hold.
// RQ4: A 16-bit select one ignores address bit 0 in its range compare.
// RQ5: Select one's two-bit mode gives disabled, read strobe, write strobe or address only.
// RQ6: Select zero has the same two-bit mode field in the low bits of the mode register.
// RQ7: A target-cycle bit limits select one to I/O cycles only or memory cycles only.
// RQ8: A separate target-cycle bit does the same for select zero.
// RQ9: Select one runs 8-bit cycles unless its width bit is set or a wide indication is active.
// RQ10: Select zero runs 8-bit cycles unless its width bit is set or a wide indication is active.
// RQ11: Reserved bits of the high-value and mode registers read as zero.
// RQ12: The clock-domain reset clears all select fields; any other reset leaves them alone.
// RQ13: Select one has a 16-bit read/write stop value, the inclusive top of its range.
// RQ14: Select one has a 16-bit read/write start value, the inclusive bottom of its range.
// RQ15: Select zero decodes the same way with its own start, stop and high values.
// RQ16: A 16-bit select zero ignores address bit 0 in its range compare.
// RQ17: A target-cycle bit of 0 means I/O cycles only and 1 means memory cycles only.
module chip_select_decode (
	input  wire logic                        clk_sys,                  // 250 MHz system clock
	input  wire logic                        reset_n,                  // Bus logic reset
	input  wire logic                        real_time_clock_reset_n,  // Clears select config
	// AXI4-Lite slave
	input  wire logic [31:0]                 s_axi_awaddr,             // Write address
	input  wire logic                        s_axi_awvalid,            // Write address valid
	output logic                             s_axi_awready,            // Write address ready
	input  wire logic [31:0]                 s_axi_wdata,              // Write data
	input  wire logic [3:0]                  s_axi_wstrb,              // Write byte strobes
	input  wire logic                        s_axi_wvalid,             // Write data valid
	output logic                             s_axi_wready,             // Write data ready
	output logic [1:0]                       s_axi_bresp,              // Write response
	output logic                             s_axi_bvalid,             // Write response valid
	input  wire logic                        s_axi_bready,             // Write response ready
	input  wire logic [31:0]                 s_axi_araddr,             // Read address
	input  wire logic                        s_axi_arvalid,            // Read address valid
	output logic                             s_axi_arready,            // Read address ready
	output logic [31:0]                      s_axi_rdata,              // Read data
	output logic [1:0]                       s_axi_rresp,              // Read response
	output logic                             s_axi_rvalid,             // Read data valid
	input  wire logic                        s_axi_rready,             // Read data ready
	// System bus cycle, same clock domain
	input  wire chip_select_pkg::bus_cycle_t bus_cycle,                // Address, strobes, type
	// External pins, asynchronous
	input  wire logic                        memory_wide_indication_n, // Memory wants 16 bit
	input  wire logic                        io_wide_indication_n,     // I/O wants 16 bit
	// Decode results
	output logic                             chip_select_zero,         // Select 0 active high
	output logic                             chip_select_one,          // Select 1 active high
	output logic                             cycle_wide                // Selected cycle is 16 bit
);
	import chip_select_pkg::*;

	// ==========================================================================
	// Helper functions
	// ==========================================================================
	// Full decode of one select against one bus cycle
	function automatic logic select_hit(select_cfg_t c, bus_cycle_t b);
		logic [15:0] lo;
		logic [15:0] st;
		logic [15:0] sp;
		logic        range_ok;
		logic        high_ok;
		logic        qual_ok;
		logic        cyc_ok;

		lo = b.addr[15:0];
		st = c.start;
		sp = c.stop;
		// Wide selects pair bytes, so the byte lane bit plays no part
		if (c.wide) begin                                   // [RQ4] [RQ16]
			lo[0] = 1'b0;
			st[0] = 1'b0;
			sp[0] = 1'b0;
		end

		range_ok = (lo >= st) && (lo <= sp);                // [RQ1] [RQ15]
		high_ok  = (b.addr[27:16] == c.high);               // [RQ2] [RQ15]
		case (c.qualifier)                                  // [RQ5] [RQ6]
			QUALIFIER_DISABLED: qual_ok = 1'b0;
			QUALIFIER_READ:     qual_ok = b.read_strobe;
			QUALIFIER_WRITE:    qual_ok = b.write_strobe;
			QUALIFIER_ADDRESS:  qual_ok = 1'b1;
			default:            qual_ok = 1'b0;
		endcase
		cyc_ok = c.cycle_mem ? ~b.io_cycle : b.io_cycle;    // [RQ7] [RQ8] [RQ17]
		return range_ok && high_ok && qual_ok && cyc_ok;    // [RQ3]
	endfunction

	// Merge a 16-bit register with byte-strobed write data
	function automatic logic [15:0] merge16(logic [15:0] old, logic [31:0] d, logic [3:0] s);
		logic [15:0] r;

		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// Word index match for a byte address
	function automatic logic at_index(logic [31:0] a, logic [31:0] idx);
		return (a[31:2] == idx[29:0]) && (a[1:0] == 2'h0);
	endfunction

	// ==========================================================================
	// Signals
	// ==========================================================================
	select_cfg_t cfg_zero_q;
	select_cfg_t cfg_one_q;

	logic        aw_full_q;
	logic        w_full_q;
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        do_write;
	logic        write_mapped;

	logic [1:0]  mem_wide_sync_q;
	logic [1:0]  io_wide_sync_q;
	logic        wide_indicated;
	logic        hit_zero;
	logic        hit_one;

	logic [15:0] mode_view;
	logic [31:0] read_word;
	logic        read_mapped;

	// ==========================================================================
	// Pin synchronisers
	// ==========================================================================
	// Wide indications come straight off the board, two flops each
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mem_wide_sync_q <= 2'h3;
			io_wide_sync_q  <= 2'h3;
		end else begin
			mem_wide_sync_q <= {mem_wide_sync_q[0], memory_wide_indication_n};
			io_wide_sync_q  <= {io_wide_sync_q[0], io_wide_indication_n};
		end
	end

	// Only the second stage is looked at
	assign wide_indicated = ~mem_wide_sync_q[1] | ~io_wide_sync_q[1];

	// ==========================================================================
	// AXI4-Lite write channel
	// ==========================================================================
	// Address and data are caught in either order; one write in flight
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			aw_addr_q     <= 32'h0000_0000;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= AXI_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end

			// Both halves held: commit and answer
			if (do_write) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= write_mapped ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
			end

			// Ready returns only once the response is gone
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

	// Write decode; the status word is read only
	always_comb begin
		write_mapped = at_index(aw_addr_q, SELECT_ZERO_START_IDX)
			|| at_index(aw_addr_q, SELECT_ZERO_STOP_IDX)
			|| at_index(aw_addr_q, SELECT_ZERO_HIGH_IDX)
			|| at_index(aw_addr_q, SELECT_ONE_START_IDX)
			|| at_index(aw_addr_q, SELECT_ONE_STOP_IDX)
			|| at_index(aw_addr_q, SELECT_ONE_HIGH_IDX)
			|| at_index(aw_addr_q, SELECT_QUALIFIER_IDX);
	end

	// ==========================================================================
	// Select configuration registers
	// ==========================================================================
	// Cleared only by the clock-domain reset; the bus reset leaves them intact
	always_ff @(posedge clk_sys or negedge real_time_clock_reset_n) begin
		if (!real_time_clock_reset_n) begin                 // [RQ12]
			cfg_zero_q <= '{start: SELECT_VALUE_RESET, stop: SELECT_VALUE_RESET,
				high: SELECT_HIGH_RESET, qualifier: QUALIFIER_DISABLED,
				wide: 1'b0, cycle_mem: 1'b0};
			cfg_one_q  <= '{start: SELECT_VALUE_RESET, stop: SELECT_VALUE_RESET,
				high: SELECT_HIGH_RESET, qualifier: QUALIFIER_DISABLED,
				wide: 1'b0, cycle_mem: 1'b0};
		end else if (do_write) begin
			if (at_index(aw_addr_q, SELECT_ZERO_START_IDX)) begin
				cfg_zero_q.start <= merge16(cfg_zero_q.start, w_data_q, w_strb_q);
			end
			if (at_index(aw_addr_q, SELECT_ZERO_STOP_IDX)) begin
				cfg_zero_q.stop <= merge16(cfg_zero_q.stop, w_data_q, w_strb_q);
			end

			// High values keep 12 bits; 15:12 read as zero
			if (at_index(aw_addr_q, SELECT_ZERO_HIGH_IDX)) begin
				cfg_zero_q.high <= 12'(merge16({4'h0, cfg_zero_q.high}, w_data_q, w_strb_q));
			end
			if (at_index(aw_addr_q, SELECT_ONE_START_IDX)) begin    // [RQ14]
				cfg_one_q.start <= merge16(cfg_one_q.start, w_data_q, w_strb_q);
			end
			if (at_index(aw_addr_q, SELECT_ONE_STOP_IDX)) begin     // [RQ13]
				cfg_one_q.stop <= merge16(cfg_one_q.stop, w_data_q, w_strb_q);
			end

			if (at_index(aw_addr_q, SELECT_ONE_HIGH_IDX)) begin
				cfg_one_q.high <= 12'(merge16({4'h0, cfg_one_q.high}, w_data_q, w_strb_q));
			end

			// Upper byte of the mode word is reserved and not stored
			if (at_index(aw_addr_q, SELECT_QUALIFIER_IDX) && w_strb_q[0]) begin
				cfg_zero_q.qualifier <=
					w_data_q[SELECT_ZERO_QUALIFIER_POS +: 2];           // [RQ6]
				cfg_zero_q.wide      <= w_data_q[SELECT_ZERO_WIDTH_POS];
				cfg_zero_q.cycle_mem <= w_data_q[SELECT_ZERO_CYCLE_TYPE_POS];
				cfg_one_q.qualifier  <=
					w_data_q[SELECT_ONE_QUALIFIER_POS +: 2];            // [RQ5]
				cfg_one_q.wide       <= w_data_q[SELECT_ONE_WIDTH_POS];
				cfg_one_q.cycle_mem  <= w_data_q[SELECT_ONE_CYCLE_TYPE_POS];
			end
		end
	end

	// ==========================================================================
	// Read view
	// ==========================================================================
	// Mode word rebuilt from fields, reserved byte at zero
	always_comb begin
		mode_view                                  = 16'h0000;  // [RQ11]
		mode_view[SELECT_ZERO_QUALIFIER_POS +: 2]  = cfg_zero_q.qualifier;
		mode_view[SELECT_ZERO_WIDTH_POS]           = cfg_zero_q.wide;
		mode_view[SELECT_ZERO_CYCLE_TYPE_POS]      = cfg_zero_q.cycle_mem;
		mode_view[SELECT_ONE_QUALIFIER_POS +: 2]   = cfg_one_q.qualifier;
		mode_view[SELECT_ONE_WIDTH_POS]            = cfg_one_q.wide;
		mode_view[SELECT_ONE_CYCLE_TYPE_POS]       = cfg_one_q.cycle_mem;
	end

	// Read mux; 16-bit registers sit in the low half, upper half zero
	always_comb begin
		read_word   = 32'h0000_0000;
		read_mapped = 1'b1;
		if (at_index(s_axi_araddr, SELECT_ZERO_START_IDX)) begin
			read_word = {16'h0000, cfg_zero_q.start};
		end else if (at_index(s_axi_araddr, SELECT_ZERO_STOP_IDX)) begin
			read_word = {16'h0000, cfg_zero_q.stop};
		end else if (at_index(s_axi_araddr, SELECT_ZERO_HIGH_IDX)) begin
			read_word = {20'h0_0000, cfg_zero_q.high};       // [RQ11]
		end else if (at_index(s_axi_araddr, SELECT_ONE_START_IDX)) begin
			read_word = {16'h0000, cfg_one_q.start};
		end else if (at_index(s_axi_araddr, SELECT_ONE_STOP_IDX)) begin
			read_word = {16'h0000, cfg_one_q.stop};
		end else if (at_index(s_axi_araddr, SELECT_ONE_HIGH_IDX)) begin
			read_word = {20'h0_0000, cfg_one_q.high};        // [RQ11]
		end else if (at_index(s_axi_araddr, SELECT_QUALIFIER_IDX)) begin
			read_word = {16'h0000, mode_view};
		end else if (at_index(s_axi_araddr, SELECT_STATUS_IDX)) begin
			read_word = {29'h0000_0000, cycle_wide, chip_select_one, chip_select_zero};
		end else begin
			read_mapped = 1'b0;
		end
	end

	// ==========================================================================
	// AXI4-Lite read channel
	// ==========================================================================
	// Answer one cycle after the address is taken
	// One read at a time: arready waits for rready
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= AXI_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= read_word;
				s_axi_rresp   <= read_mapped ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// Chip select decode
	// ==========================================================================
	// Both selects share one decode function so they cannot drift apart
	always_comb begin
		hit_zero = select_hit(cfg_zero_q, bus_cycle);       // [RQ15]
		hit_one  = select_hit(cfg_one_q, bus_cycle);        // [RQ3]
	end

	// Registered outputs cost one cycle of latency but give clean pins
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			chip_select_zero <= 1'b0;
			chip_select_one  <= 1'b0;
			cycle_wide       <= 1'b0;
		end else begin
			chip_select_zero <= hit_zero;
			chip_select_one  <= hit_one;
			cycle_wide       <= (hit_zero && (cfg_zero_q.wide || wide_indicated))  // [RQ10]
				|| (hit_one && (cfg_one_q.wide || wide_indicated));                // [RQ9]
		end
	end

endmodule // chip_select_decode

// ===== chip_select_pkg.sv
package chip_select_pkg;

	// ==========================================================================
	// Register indices (byte address is four times the index)
	// ==========================================================================
	localparam logic [31:0] SELECT_ZERO_START_IDX = 32'h0b00_0320;
	localparam logic [31:0] SELECT_ZERO_STOP_IDX  = 32'h0b00_0322;
	localparam logic [31:0] SELECT_ZERO_HIGH_IDX  = 32'h0b00_0324;
	localparam logic [31:0] SELECT_ONE_START_IDX  = 32'h0b00_0326;
	localparam logic [31:0] SELECT_ONE_STOP_IDX   = 32'h0b00_0328;
	localparam logic [31:0] SELECT_ONE_HIGH_IDX   = 32'h0b00_032a;
	localparam logic [31:0] SELECT_QUALIFIER_IDX  = 32'h0b00_032c;
	localparam logic [31:0] SELECT_STATUS_IDX     = 32'h0b00_03f0;

	// ==========================================================================
	// Field layout of the qualifier register
	// ==========================================================================
	localparam int SELECT_ZERO_QUALIFIER_POS  = 0;
	localparam int SELECT_ZERO_WIDTH_POS      = 2;
	localparam int SELECT_ZERO_CYCLE_TYPE_POS = 3;
	localparam int SELECT_ONE_QUALIFIER_POS   = 4;
	localparam int SELECT_ONE_WIDTH_POS       = 6;
	localparam int SELECT_ONE_CYCLE_TYPE_POS  = 7;

	// ==========================================================================
	// Qualifier encodings, reset values, bus answers
	// ==========================================================================
	localparam logic [1:0] QUALIFIER_DISABLED = 2'h0;
	localparam logic [1:0] QUALIFIER_READ     = 2'h1;
	localparam logic [1:0] QUALIFIER_WRITE    = 2'h2;
	localparam logic [1:0] QUALIFIER_ADDRESS  = 2'h3;

	localparam logic [15:0] SELECT_VALUE_RESET = 16'h0000;
	localparam logic [11:0] SELECT_HIGH_RESET  = 12'h000;
	localparam logic [1:0]  AXI_RESP_OKAY      = 2'h0;
	localparam logic [1:0]  AXI_RESP_SLVERR    = 2'h2;

	// ==========================================================================
	// Carriers
	// ==========================================================================
	// One select's whole configuration
	typedef struct packed {
		logic [15:0] start;
		logic [15:0] stop;
		logic [11:0] high;
		logic [1:0]  qualifier;
		logic        wide;
		logic        cycle_mem;
	} select_cfg_t;

	// One system bus cycle as seen by the decoder
	typedef struct packed {
		logic [27:0] addr;
		logic        read_strobe;
		logic        write_strobe;
		logic        io_cycle;
	} bus_cycle_t;

endpackage

// ===== chip_select_monitor.sv
`timescale 1ns/1ps

// ==========================================
// Port checker
module chip_select_monitor (
	input wire logic                        clk_sys,                 // System clock
	input wire logic                        reset_n,                 // Bus reset
	input wire logic                        real_time_clock_reset_n, // Config clear
	input wire logic [31:0]                 s_axi_awaddr,            // Write address
	input wire logic                        s_axi_awvalid,           // Write address valid
	input wire logic                        s_axi_awready,           // Write address ready
	input wire logic [31:0]                 s_axi_wdata,             // Write data
	input wire logic [3:0]                  s_axi_wstrb,             // Write strobes
	input wire logic                        s_axi_wvalid,            // Write data valid
	input wire logic                        s_axi_wready,            // Write data ready
	input wire logic                        s_axi_bvalid,            // Write response valid
	input wire logic                        s_axi_bready,            // Write response ready
	input wire logic                        s_axi_arvalid,           // Read address valid
	input wire logic                        s_axi_arready,           // Read address ready
	input wire logic                        s_axi_rvalid,            // Read data valid
	input wire chip_select_pkg::bus_cycle_t bus_cycle,               // System bus cycle
	input wire logic                        chip_select_zero,        // Select 0
	input wire logic                        chip_select_one,         // Select 1
	input wire logic                        cycle_wide               // 16-bit cycle
);
	import chip_select_pkg::*;
	localparam logic [31:0] MODE_ADDR = {SELECT_QUALIFIER_IDX[29:0], 2'b00};
	logic       pend_q;
	logic [7:0] data_q;
	logic [7:0] mode_q;

	// Snooped mode write; lands one edge after it is taken
	always_ff @(posedge clk_sys or negedge reset_n or negedge real_time_clock_reset_n) begin
		if (!reset_n || !real_time_clock_reset_n) begin
			pend_q <= 1'b0;
			data_q <= 8'h00;
		end else begin
			pend_q <= s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
				&& s_axi_awaddr == MODE_ADDR && s_axi_wstrb[0];
			data_q <= s_axi_wdata[7:0];
		end
	end

	// Shadow of the mode byte; bus reset leaves it alone
	always_ff @(posedge clk_sys or negedge real_time_clock_reset_n) begin
		if (!real_time_clock_reset_n) mode_q <= 8'h00;
		else if (pend_q) mode_q <= data_q;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// ==========================================
	// Bus answers
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write response");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& !s_axi_arready) else $error("no read answer");

	// ==========================================
	// Decode qualifiers, cycle types and widths
	zero_disabled_a: assert property (mode_q[1:0] == QUALIFIER_DISABLED
		|=> !chip_select_zero) else $error("disabled select zero fired");
	zero_write_qual_a: assert property (mode_q[1:0] == QUALIFIER_WRITE
		&& !bus_cycle.write_strobe |=> !chip_select_zero)
		else $error("select zero without write strobe");
	one_read_qual_a: assert property (mode_q[5:4] == QUALIFIER_READ && !bus_cycle.read_strobe
		|=> !chip_select_one) else $error("select one without read strobe");
	zero_cycle_type_a: assert property (mode_q[3] == bus_cycle.io_cycle
		|=> !chip_select_zero) else $error("select zero on wrong cycle type");
	one_cycle_type_a: assert property (mode_q[7] == bus_cycle.io_cycle
		|=> !chip_select_one) else $error("select one on wrong cycle type");
	zero_width_a: assert property (mode_q[2] |=> (chip_select_zero |-> cycle_wide))
		else $error("wide select zero ran narrow");
	one_width_a: assert property (mode_q[6] |=> (chip_select_one |-> cycle_wide))
		else $error("wide select one ran narrow");
	wide_needs_hit_a: assert property (cycle_wide |-> chip_select_zero || chip_select_one)
		else $error("wide cycle with no select");
endmodule // chip_select_monitor

bind chip_select_decode chip_select_monitor mon_u (.clk_sys, .reset_n, .real_time_clock_reset_n,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.bus_cycle, .chip_select_zero, .chip_select_one, .cycle_wide);

// ===== wide_device_model.sv
`timescale 1ns/1ps

// ==========================================
// Far-side devices that claim 16-bit cycles
module wide_device_model (
	input  wire logic [1:0] claim_wide,               // Bit 0 memory, bit 1 I/O claims
	output logic            memory_wide_indication_n, // Memory 16-bit claim
	output logic            io_wide_indication_n      // I/O 16-bit claim
);
	// Pulled up: a device that claims nothing leaves the pin high
	assign memory_wide_indication_n = ~claim_wide[0];
	assign io_wide_indication_n = ~claim_wide[1];
endmodule // wide_device_model

// ===== programmable_chip_select_decode_tb.sv
`timescale 1ns/1ps

module programmable_chip_select_decode_tb;
	import chip_select_pkg::*;
	logic clk_sys = 0, reset_n = 0, rtc_n = 0, cs0, cs1, wide, mem_n, io_n;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, claim = 0;
	bus_cycle_t bus_cycle = '0;
	int mismatches = 0, n_compared = 0;
	int cfg [7];
	int mask [7] = '{16'hffff, 16'hffff, 12'hfff, 16'hffff, 16'hffff, 12'hfff, 8'hff};
	logic [31:0] idx [7] = '{SELECT_ZERO_START_IDX, SELECT_ZERO_STOP_IDX, SELECT_ZERO_HIGH_IDX,
		SELECT_ONE_START_IDX, SELECT_ONE_STOP_IDX, SELECT_ONE_HIGH_IDX, SELECT_QUALIFIER_IDX};

	chip_select_decode dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
		.real_time_clock_reset_n(rtc_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.bus_cycle(bus_cycle), .memory_wide_indication_n(mem_n), .io_wide_indication_n(io_n),
		.chip_select_zero(cs0), .chip_select_one(cs1), .cycle_wide(wide));
	wide_device_model far_u (.claim_wide(claim), .memory_wide_indication_n(mem_n),
		.io_wide_indication_n(io_n));

	always #2 clk_sys = ~clk_sys;

	// ==========================================
	// Checking and closing
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask

	task automatic conclude();
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Well above the run's length
	initial begin
		repeat (30000) @(posedge clk_sys);
		mismatches++;
		conclude();
	end

	// ==========================================
	// Register bus master; each channel released once its ready is seen
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'b111;
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
	endtask

	function automatic logic [31:0] ba(int i);
		return {idx[i][29:0], 2'b00};
	endfunction

	// Write one register, track its model value
	task automatic set(int i, int v);
		logic [1:0] r;
		wr(ba(i), v, r);
		cfg[i] = v & mask[i];
		chk("write resp", AXI_RESP_OKAY, r);
	endtask

	task automatic check_all(input string nm);
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 7; i++) begin
			rd(ba(i), d, r);
			chk(nm, cfg[i], d);
			chk("read resp", AXI_RESP_OKAY, r);
		end
	endtask

	// ==========================================
	// Reference decode from the held configuration
	function automatic bit hit(int s, bus_cycle_t c);
		int m = cfg[6] >> (4 * s);
		int a = c.addr[15:0];
		int lo = cfg[3 * s];
		int hi = cfg[3 * s + 1];
		if (m & 4) begin
			a &= 16'hfffe;
			lo &= 16'hfffe;
			hi &= 16'hfffe;
		end
		return a >= lo && a <= hi && c.addr[27:16] == cfg[3 * s + 2]
			&& ((m & 3) == 3 || ((m & 3) == 1 && c.read_strobe) || ((m & 3) == 2 && c.write_strobe))
			&& ((m & 8) ? !c.io_cycle : c.io_cycle);
	endfunction

	// Addresses aimed at window edges, where off-by-one slips show
	task automatic sample();
		bus_cycle_t c;
		int s = $urandom_range(1);
		logic [15:0] low;
		bit h0, h1, pin, w;
		logic [31:0] st;
		logic [1:0] r;
		case ($urandom_range(4))
			0: low = 16'(cfg[3 * s]);
			1: low = 16'(cfg[3 * s + 1]);
			2: low = 16'(cfg[3 * s] - 1);
			3: low = 16'(cfg[3 * s + 1] + 1);
			default: low = 16'($urandom);
		endcase
		c.addr = {($urandom_range(3) != 0) ? 12'(cfg[3 * s + 2]) : 12'($urandom), low};
		{c.read_strobe, c.write_strobe, c.io_cycle} = 3'($urandom);
		@(posedge clk_sys);
		bus_cycle <= c;
		h0 = hit(0, c);
		h1 = hit(1, c);
		pin = claim != 2'b00;
		@(posedge clk_sys);
		#1;
		chk("select zero", h0, cs0);
		chk("select one", h1, cs1);
		w = (h0 && (cfg[6][2] || pin)) || (h1 && (cfg[6][6] || pin));
		chk("cycle width", w, wide);
		rd({SELECT_STATUS_IDX[29:0], 2'b00}, st, r);
		chk("status word", {w, h1, h0}, st);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int lo;
		void'($urandom(32'heb2d_2787));
		repeat (8) @(posedge clk_sys);
		{reset_n, rtc_n} <= 2'b11;
		check_all("reset value");
		for (int i = 0; i < 7; i++) set(i, $urandom);
		check_all("readback");
		rd(32'h2c00_0cb4, d, r);
		chk("unmapped read resp", AXI_RESP_SLVERR, r);
		chk("unmapped read data", 32'h0000_0000, d);
		wr(32'h2c00_0cb4, 32'hffff_ffff, r);
		chk("unmapped write resp", AXI_RESP_SLVERR, r);
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		check_all("after bus reset");
		// Every pair of qualifier codes, random width and cycle-type bits
		for (int k = 0; k < 16; k++) begin
			claim <= 2'($urandom);
			for (int s = 0; s < 2; s++) begin
				lo = $urandom_range(16'hffff);
				set(3 * s, lo);
				set(3 * s + 1, lo + $urandom_range(40));
				set(3 * s + 2, $urandom);
			end
			set(6, (k & 3) | ((k >> 2) << 4) | ($urandom & 8'hcc));
			repeat (30) sample();
		end
		@(posedge clk_sys);
		rtc_n <= 1'b0;
		@(posedge clk_sys);
		rtc_n <= 1'b1;
		foreach (cfg[i]) cfg[i] = 0;
		check_all("after clock reset");
		repeat (4) sample();
		conclude();
	end
endmodule // programmable_chip_select_decode_tb
